// ### hw/tcc_core.sv
// The placing of the registers and the APB slave port were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
// Summary of operation
// RULE1: 16-bit count steps on each timer tick
// RULE2: Clear zeroes count, prescaler and direction
// RULE3: Clock from aux, sub-main or external input
// RULE4: Divide source by 1, 2, 4 or 8
// RULE5: Down-counter prescaler, first edge ticks immediately
// RULE6: Count writes immediate, raise no flags
// RULE7: Counts only with nonzero mode and running clock
// RULE8: Zero period stops; nonzero restarts up from zero
// RULE9: Mode codes stop, up, continuous, up/down
// RULE10: Up mode counts zero to period, wraps
// RULE11: Count above period in up returns to zero
// RULE12: Up mode: compare at period, rollover at wrap
// RULE13: Period shrink below count rolls to zero
// RULE14: Continuous mode wraps at full scale
// RULE15: Continuous rollover flag at full-scale wrap
// RULE16: Up/down counts to period and back
// RULE17: Direction latched; only clear resets it; here a period restart from zero also resets it
// RULE18: Up/down flags at period step and 1-to-0
// RULE19: Software halts timer before reconfiguring
// RULE20: Software reads count while halted or votes
// RULE21: Reset clears count, prescaler, mode, direction, flags
module tcc_core
    import tcc_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        aux_clock,
    input  wire logic        sub_main_clock,
    input  wire logic        external_timer_clock,
    output logic [15:0]      count_value,
    output logic             rollover_flag,
    output logic             compare_match_flag
);
    import tcc_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Bus decode
    tcc_ctrl_t   ctrl;
    logic [15:0] count_register;
    logic [15:0] period_compare_register;
    logic        count_down;
    logic        wr_en;
    logic        rd_en;
    logic        wr_ctrl;
    logic        wr_count;
    logic        wr_period;
    logic        wr_flags;
    logic        hit;

    assign wr_en = psel && penable && pwrite;
    assign rd_en = psel && !penable && !pwrite; // Setup cycle
    assign pready = 1'b1;

    // Address decode as if/else-if chain
    always_comb begin
        wr_ctrl   = 1'b0;
        wr_count  = 1'b0;
        wr_period = 1'b0;
        wr_flags  = 1'b0;
        hit       = 1'b1;
        if (paddr == OFS_CTRL) begin
            wr_ctrl = wr_en;
        end else if (paddr == OFS_COUNT) begin
            wr_count = wr_en;
        end else if (paddr == OFS_PERIOD) begin
            wr_period = wr_en;
        end else if (paddr == OFS_FLAGS) begin
            wr_flags = wr_en;
        end else begin
            hit = 1'b0;
        end
    end

    // Unmapped addresses answer with an error and zero data
    assign pslverr = psel && penable && !hit;

    // Read data captured in setup; zero-wait access must find it standing
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= UNMAPPED_RD;
        end else if (rd_en) begin
            if (paddr == OFS_CTRL) begin
                prdata <= {25'h0, ctrl};
            end else if (paddr == OFS_COUNT) begin
                prdata <= {16'h0, count_register};
            end else if (paddr == OFS_PERIOD) begin
                prdata <= {16'h0, period_compare_register};
            end else if (paddr == OFS_FLAGS) begin
                prdata <= {29'h0, count_down, compare_match_flag, rollover_flag};
            end else begin
                prdata <= UNMAPPED_RD;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Control registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl <= tcc_ctrl_t'(CTRL_RST); // RULE21
        end else if (wr_ctrl) begin
            ctrl <= tcc_ctrl_t'(pwdata[6:0]);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            period_compare_register <= PERIOD_RST;
        end else if (wr_period) begin
            period_compare_register <= pwdata[15:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Clock selection and prescaling
    logic aux_rise;
    logic sub_rise;
    logic ext_rise;
    logic src_edge;
    logic tick;

    tcc_sync u_sync_aux (
        .pclk     (pclk),
        .presetn  (presetn),
        .async_in (aux_clock),
        .rise     (aux_rise)
    );
    tcc_sync u_sync_sub (
        .pclk     (pclk),
        .presetn  (presetn),
        .async_in (sub_main_clock),
        .rise     (sub_rise)
    );
    tcc_sync u_sync_ext (
        .pclk     (pclk),
        .presetn  (presetn),
        .async_in (external_timer_clock),
        .rise     (ext_rise)
    );

    // Reserved source code gives no clock at all
    always_comb begin
        case (ctrl.src)
            TCC_SRC_AUX: src_edge = aux_rise; // RULE3
            TCC_SRC_SUB: src_edge = sub_rise; // RULE3
            TCC_SRC_EXT: src_edge = ext_rise; // RULE3
            default:     src_edge = 1'b0;
        endcase
    end

    tcc_prescale u_prescale (
        .pclk     (pclk),
        .presetn  (presetn),
        .clear    (ctrl.clear),
        .src_edge (src_edge),
        .div      (ctrl.div),
        .tick     (tick)
    );

    ////////////////////////////////////////////////////////////////////////
    // Counter next-state
    logic [15:0] next_count;
    logic        next_down;
    logic        step;
    logic        set_roll;
    logic        set_cmp;

    // Zero period halts the period-based modes
    assign step = tick && (ctrl.mode != TCC_STOP) && !wr_count && !ctrl.clear &&
                  !((ctrl.mode == TCC_UP || ctrl.mode == TCC_UPDN) &&
                    period_compare_register == 16'h0000); // RULE7 RULE8

    always_comb begin
        next_count = count_register;
        next_down  = count_down;
        set_roll   = 1'b0;
        set_cmp    = 1'b0;
        case (ctrl.mode) // RULE9
            TCC_UP: begin
                // Period reached or overshot wraps to zero
                if (count_register >= period_compare_register) begin
                    next_count = 16'h0000; // RULE10 RULE11 RULE13
                    set_roll   = (count_register == period_compare_register); // RULE12
                end else begin
                    next_count = count_register + 16'h0001; // RULE1
                    set_cmp    = (next_count == period_compare_register); // RULE12
                end
            end
            TCC_CONT: begin
                next_count = count_register + 16'h0001; // RULE14
                set_roll   = (count_register == FULL_SCALE); // RULE15
            end
            TCC_UPDN: begin
                if (!count_down) begin
                    if (count_register >= period_compare_register) begin
                        // Over the period turns round at once
                        next_down  = 1'b1; // RULE16
                        next_count = count_register - 16'h0001;
                    end else begin
                        next_count = count_register + 16'h0001;
                        set_cmp    = (next_count == period_compare_register); // RULE18
                        next_down  = (next_count == period_compare_register);
                    end
                end else begin
                    next_count = count_register - 16'h0001; // RULE16
                    set_roll   = (count_register == 16'h0001); // RULE18
                    if (count_register == 16'h0001) begin
                        next_down = 1'b0;
                    end
                end
            end
            default: begin
                next_count = count_register;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Count register: clear beats writes beats counting
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_register <= COUNT_RST; // RULE21
        end else if (ctrl.clear) begin
            count_register <= COUNT_RST; // RULE2
        end else if (wr_count) begin
            count_register <= pwdata[15:0]; // RULE6
        end else if (wr_period && pwdata[15:0] != 16'h0000 &&
                     period_compare_register == 16'h0000 &&
                     (ctrl.mode == TCC_UP || ctrl.mode == TCC_UPDN)) begin
            count_register <= COUNT_RST; // RULE8
        end else if (step) begin
            count_register <= next_count; // RULE1
        end
    end

    // Direction survives stop; only clear, reset or a period restart from zero resets it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_down <= 1'b0; // RULE21
        end else if (ctrl.clear) begin
            count_down <= 1'b0; // RULE2 RULE17
        end else if (wr_period && pwdata[15:0] != 16'h0000 &&
                     period_compare_register == 16'h0000 &&
                     (ctrl.mode == TCC_UP || ctrl.mode == TCC_UPDN)) begin
            count_down <= 1'b0; // RULE8
        end else if (step && ctrl.mode == TCC_UPDN) begin
            count_down <= next_down; // RULE17
        end
    end

    // Sticky flags; a hardware set wins over a software clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rollover_flag      <= 1'b0; // RULE21
            compare_match_flag <= 1'b0; // RULE21
        end else begin
            if (step && set_roll) begin
                rollover_flag <= 1'b1;
            end else if (wr_flags && pwdata[FLG_ROLL_BIT]) begin
                rollover_flag <= 1'b0;
            end
            if (step && set_cmp) begin
                compare_match_flag <= 1'b1;
            end else if (wr_flags && pwdata[FLG_CMP_BIT]) begin
                compare_match_flag <= 1'b0;
            end
        end
    end

    assign count_value = count_register;

    ////////////////////////////////////////////////////////////////////////
    // Checks
    // Up/down turn: the last upward step lands on the period
    sequence s_updn_turn;
        step && ctrl.mode == TCC_UPDN && !count_down &&
        count_register + 16'h0001 == period_compare_register;
    endsequence

    // Up/down bottom: the last downward step lands on zero
    sequence s_updn_bottom;
        step && ctrl.mode == TCC_UPDN && count_down && count_register == 16'h0001;
    endsequence

    chk_clear_zero: assert property (@(posedge pclk) disable iff (!presetn) // RULE2
        ctrl.clear |=> count_register == 16'h0000 && !count_down)
        else $error("clear did not zero count");
    chk_stop_hold: assert property (@(posedge pclk) disable iff (!presetn) // RULE7
        ctrl.mode == TCC_STOP && !wr_count && !ctrl.clear |=> $stable(count_register))
        else $error("count moved in stop mode");
    chk_write_now: assert property (@(posedge pclk) disable iff (!presetn) // RULE6
        wr_count && !ctrl.clear |=> count_register == $past(pwdata[15:0]))
        else $error("count write not immediate");
    chk_write_noflag: assert property (@(posedge pclk) disable iff (!presetn) // RULE6
        wr_count && !rollover_flag |=> !rollover_flag)
        else $error("count write raised rollover");
    chk_write_nocmp: assert property (@(posedge pclk) disable iff (!presetn) // RULE6
        wr_count && !compare_match_flag |=> !compare_match_flag)
        else $error("count write raised compare");
    chk_up_wrap: assert property (@(posedge pclk) disable iff (!presetn) // RULE10 RULE12
        step && ctrl.mode == TCC_UP && count_register == period_compare_register
        |=> count_register == 16'h0000 && rollover_flag)
        else $error("up mode wrap wrong");
    chk_up_cmp: assert property (@(posedge pclk) disable iff (!presetn) // RULE12
        step && ctrl.mode == TCC_UP &&
        count_register + 16'h0001 == period_compare_register |=> compare_match_flag)
        else $error("up mode compare flag missing");
    chk_up_over: assert property (@(posedge pclk) disable iff (!presetn) // RULE11 RULE13
        step && ctrl.mode == TCC_UP && count_register > period_compare_register
        |=> count_register == 16'h0000)
        else $error("up mode overshoot not zeroed");
    chk_cont_wrap: assert property (@(posedge pclk) disable iff (!presetn) // RULE14 RULE15
        step && ctrl.mode == TCC_CONT && count_register == 16'hffff
        |=> count_register == 16'h0000 && rollover_flag)
        else $error("continuous wrap wrong");
    chk_cont_step: assert property (@(posedge pclk) disable iff (!presetn) // RULE14
        step && ctrl.mode == TCC_CONT && count_register != FULL_SCALE
        |=> count_register == $past(count_register) + 16'h0001)
        else $error("continuous step wrong");
    chk_updn_cmp: assert property (@(posedge pclk) disable iff (!presetn) // RULE16 RULE18
        s_updn_turn |=> compare_match_flag && count_down)
        else $error("up/down turn wrong");
    chk_updn_roll: assert property (@(posedge pclk) disable iff (!presetn) // RULE18
        s_updn_bottom |=> count_register == 16'h0000 && rollover_flag && !count_down)
        else $error("up/down bottom wrong");
    chk_dir_hold: assert property (@(posedge pclk) disable iff (!presetn) // RULE17
        !ctrl.clear && !wr_period && !(step && ctrl.mode == TCC_UPDN) |=> $stable(count_down))
        else $error("direction changed while idle");
    chk_zero_period: assert property (@(posedge pclk) disable iff (!presetn) // RULE8
        (ctrl.mode == TCC_UP || ctrl.mode == TCC_UPDN) &&
        period_compare_register == 16'h0000 &&
        !wr_count && !wr_period && !ctrl.clear |=> $stable(count_register))
        else $error("zero period did not stop");
endmodule : tcc_core
`default_nettype wire

// ### hw/tcc_pkg.sv
package tcc_pkg;
    // Register byte offsets
    localparam logic [7:0]  OFS_CTRL     = 8'h00;
    localparam logic [7:0]  OFS_COUNT    = 8'h04;
    localparam logic [7:0]  OFS_PERIOD   = 8'h08;
    localparam logic [7:0]  OFS_FLAGS    = 8'h0c;
    // Control and flag field positions
    localparam int          CTL_MODE_LSB = 0;
    localparam int          CTL_DIV_LSB  = 2;
    localparam int          CTL_SRC_LSB  = 4;
    localparam int          CTL_CLR_BIT  = 6;
    localparam int          FLG_ROLL_BIT = 0;
    localparam int          FLG_CMP_BIT  = 1;
    localparam int          FLG_DIR_BIT  = 2;
    // Reset values and full-scale count
    localparam logic [15:0] COUNT_RST    = 16'h0000;
    localparam logic [15:0] PERIOD_RST   = 16'h0000;
    localparam logic [15:0] FULL_SCALE   = 16'hffff;
    localparam logic [31:0] UNMAPPED_RD  = 32'h00000000;

    typedef enum logic [1:0] {
        TCC_STOP = 2'b00,
        TCC_UP   = 2'b01,
        TCC_CONT = 2'b10,
        TCC_UPDN = 2'b11
    } tcc_mode_t;

    typedef enum logic [1:0] {
        TCC_SRC_AUX = 2'b00,
        TCC_SRC_SUB = 2'b01,
        TCC_SRC_EXT = 2'b10,
        TCC_SRC_RSV = 2'b11
    } tcc_src_t;

    typedef struct packed {
        logic        clear;
        tcc_src_t    src;
        logic [1:0]  div;
        tcc_mode_t   mode;
    } tcc_ctrl_t;

    localparam logic [6:0]  CTRL_RST     = 7'h00;
endpackage : tcc_pkg

// ### hw/tcc_prescale.sv
`timescale 1ns/100ps
`default_nettype none
// Down-counting prescaler turning source edges into timer ticks
module tcc_prescale (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       clear,
    input  wire logic       src_edge,
    input  wire logic [1:0] div,
    output logic            tick
);
    logic [2:0] remain;

    // First edge after clear ticks at once, later ones per ratio
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            remain <= 3'h0;
        end else if (clear) begin
            remain <= 3'h0; // RULE2
        end else if (src_edge) begin
            if (remain == 3'h0) begin
                remain <= 3'((4'h1 << div) - 4'h1); // RULE4 RULE5
            end else begin
                remain <= remain - 3'h1;
            end
        end
    end

    assign tick = src_edge && !clear && (remain == 3'h0); // RULE5
endmodule : tcc_prescale
`default_nettype wire

// ### hw/tcc_sync.sv
`timescale 1ns/100ps
`default_nettype none
// Three-stage synchroniser with edge detect on agreeing stages 2 and 3
module tcc_sync (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic async_in,
    output logic      rise
);
    logic s1;
    logic s2;
    logic s3;
    logic level;

    // Only s2 reads s1; edge uses stable copy
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1    <= 1'b0;
            s2    <= 1'b0;
            s3    <= 1'b0;
            level <= 1'b0;
        end else begin
            s1 <= async_in;
            s2 <= s1;
            s3 <= s2;
            if (s2 == s3) begin
                level <= s3;
            end
        end
    end

    assign rise = (s2 == s3) && s3 && !level;
endmodule : tcc_sync
`default_nettype wire

// ### verif/tb_timer_counter_core.sv
`timescale 1ns/100ps
`default_nettype none
// One compare: counts it, reports a mismatch at once
`define CHK(nm, exp, got) begin n_checks++; if ((got) !== (exp)) begin err_count++; \
    $display("mismatch %s expected %h seen %h", nm, exp, got); end end
module tb_timer_counter_core;
    import tcc_pkg::*;
    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [2:0]  clks;
    logic [15:0] count_value;
    logic        rollover_flag;
    logic        compare_match_flag;
    logic [31:0] rd;
    logic        er;
    int          err_count;
    int          n_checks;

    tcc_core dut (
        .pclk                 (pclk),
        .presetn              (presetn),
        .psel                 (psel),
        .penable              (penable),
        .pwrite               (pwrite),
        .paddr                (paddr),
        .pwdata               (pwdata),
        .prdata               (prdata),
        .pready               (pready),
        .pslverr              (pslverr),
        .aux_clock            (clks[0]),
        .sub_main_clock       (clks[1]),
        .external_timer_clock (clks[2]),
        .count_value          (count_value),
        .rollover_flag        (rollover_flag),
        .compare_match_flag   (compare_match_flag)
    );

    // 40 MHz bus clock
    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Verdict, the single exit of the run
    task results;
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : results

    // APB transfer; response and read data taken at the pready edge
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d,
             output logic [31:0] q, output logic e);
        int i;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (i = 0; i < 16; i++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        if (i == 16) begin
            err_count++;
            results();
        end
        e = pslverr;
        q = prdata;
        psel    <= 1'b0;
        penable <= 1'b0;
        // One idle edge so a write's effect has settled on return
        @(posedge pclk);
    endtask : apb

    task wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d, rd, er);
    endtask : wr

    task rd_chk(input logic [7:0] a, input logic [31:0] e, input string nm);
        apb(1'b0, a, 32'h0, rd, er);
        `CHK(nm, e, rd)
        `CHK("read err", 1'b0, er)
    endtask : rd_chk

    task ctl(input tcc_mode_t m, input logic [1:0] d, input tcc_src_t s, input logic c);
        tcc_ctrl_t v;
        v = '{clear: c, src: s, div: d, mode: m};
        wr(OFS_CTRL, {25'h0, v});
    endtask : ctl

    // Slow source pulses, 4 cycles high and low, so the synchroniser never misses one
    task edges(input int s, input int n);
        for (int k = 0; k < n; k++) begin
            @(posedge pclk);
            clks[s] <= 1'b1;
            repeat (4) @(posedge pclk);
            clks[s] <= 1'b0;
            repeat (3) @(posedge pclk);
        end
        repeat (4) @(posedge pclk);
    endtask : edges

    ////////////////////////////////////////////////////////////////////////////////
    task t_reset;
        rd_chk(OFS_CTRL, {25'h0, CTRL_RST}, "ctrl");
        rd_chk(OFS_COUNT, {16'h0, COUNT_RST}, "count");
        rd_chk(OFS_PERIOD, {16'h0, PERIOD_RST}, "period");
        rd_chk(OFS_FLAGS, 32'h0, "flags");
        apb(1'b1, 8'h14, 32'h0000ffff, rd, er);
        `CHK("unmapped wr err", 1'b1, er)
        apb(1'b0, 8'h10, 32'h0, rd, er);
        `CHK("unmapped rd", UNMAPPED_RD, rd)
    endtask : t_reset

    // Stop mode, dead source and unselected sources must not count
    task t_stop;
        wr(OFS_COUNT, 32'h5);
        `CHK("count write", 16'h0005, count_value)
        ctl(TCC_STOP, 2'b00, TCC_SRC_AUX, 1'b0);
        edges(0, 3);
        `CHK("stop count", 16'h0005, count_value)
        ctl(TCC_CONT, 2'b00, TCC_SRC_RSV, 1'b0);
        edges(0, 2);
        `CHK("no source", 16'h0005, count_value)
        ctl(TCC_CONT, 2'b00, TCC_SRC_SUB, 1'b0);
        edges(0, 2);
        edges(1, 2);
        `CHK("sub source", 16'h0007, count_value)
        ctl(TCC_CONT, 2'b00, TCC_SRC_EXT, 1'b0);
        edges(0, 1);
        edges(2, 1);
        `CHK("ext source", 16'h0008, count_value)
    endtask : t_stop

    task t_cont;
        wr(OFS_FLAGS, 32'h3);
        wr(OFS_COUNT, 32'hfffd);
        ctl(TCC_CONT, 2'b00, TCC_SRC_AUX, 1'b0);
        edges(0, 2);
        `CHK("cont full", FULL_SCALE, count_value)
        `CHK("cont no roll", 1'b0, rollover_flag)
        edges(0, 1);
        `CHK("cont wrap", 16'h0000, count_value)
        `CHK("cont roll", 1'b1, rollover_flag)
    endtask : t_cont

    // Each divide code from a cleared prescaler: first edge ticks, then every N
    task t_div;
        for (int d = 0; d < 4; d++) begin
            ctl(TCC_CONT, 2'(d), TCC_SRC_SUB, 1'b1);
            @(posedge pclk);
            `CHK("clear count", 16'h0000, count_value)
            ctl(TCC_CONT, 2'(d), TCC_SRC_SUB, 1'b0);
            edges(1, 8);
            `CHK("div ticks", 16'(1 + (7 >> d)), count_value)
        end
    endtask : t_div

    task t_up;
        ctl(TCC_STOP, 2'b00, TCC_SRC_EXT, 1'b1);
        wr(OFS_PERIOD, 32'h3);
        wr(OFS_FLAGS, 32'h3);
        ctl(TCC_UP, 2'b00, TCC_SRC_EXT, 1'b0);
        wr(OFS_COUNT, 32'h3);
        `CHK("load no cmp", 1'b0, compare_match_flag)
        wr(OFS_COUNT, 32'h0);
        edges(2, 3);
        `CHK("up top", 16'h0003, count_value)
        `CHK("up cmp", 1'b1, compare_match_flag)
        `CHK("up no roll", 1'b0, rollover_flag)
        edges(2, 1);
        `CHK("up wrap", 16'h0000, count_value)
        `CHK("up roll", 1'b1, rollover_flag)
        wr(OFS_FLAGS, 32'h3);
        rd_chk(OFS_FLAGS, 32'h0, "flags w1c");
        ctl(TCC_STOP, 2'b00, TCC_SRC_EXT, 1'b0);
        wr(OFS_COUNT, 32'h9);
        ctl(TCC_UP, 2'b00, TCC_SRC_EXT, 1'b0);
        edges(2, 1);
        `CHK("above period", 16'h0000, count_value)
        wr(OFS_PERIOD, 32'ha);
        edges(2, 6);
        wr(OFS_PERIOD, 32'h4);
        edges(2, 1);
        `CHK("period shrink", 16'h0000, count_value)
    endtask : t_up

    task t_updn;
        ctl(TCC_STOP, 2'b00, TCC_SRC_AUX, 1'b1);
        wr(OFS_PERIOD, 32'h3);
        wr(OFS_FLAGS, 32'h3);
        ctl(TCC_UPDN, 2'b00, TCC_SRC_AUX, 1'b0);
        edges(0, 2);
        `CHK("ud no cmp", 1'b0, compare_match_flag)
        edges(0, 1);
        `CHK("ud top", 16'h0003, count_value)
        `CHK("ud cmp", 1'b1, compare_match_flag)
        edges(0, 1);
        apb(1'b0, OFS_FLAGS, 32'h0, rd, er);
        `CHK("dir down", 1'b1, rd[FLG_DIR_BIT])
        ctl(TCC_STOP, 2'b00, TCC_SRC_AUX, 1'b0);
        edges(0, 2);
        ctl(TCC_UPDN, 2'b00, TCC_SRC_AUX, 1'b0);
        edges(0, 1);
        `CHK("resume down", 16'h0001, count_value)
        `CHK("ud no roll", 1'b0, rollover_flag)
        edges(0, 1);
        `CHK("ud bottom", 16'h0000, count_value)
        `CHK("ud roll", 1'b1, rollover_flag)
        edges(0, 4);
        ctl(TCC_STOP, 2'b00, TCC_SRC_AUX, 1'b1);
        apb(1'b0, OFS_FLAGS, 32'h0, rd, er);
        `CHK("dir cleared", 1'b0, rd[FLG_DIR_BIT])
    endtask : t_updn

    // Zero period halts; a nonzero one restarts upward from zero
    task t_zero;
        wr(OFS_PERIOD, 32'h5);
        ctl(TCC_UPDN, 2'b00, TCC_SRC_AUX, 1'b0);
        edges(0, 2);
        wr(OFS_PERIOD, 32'h0);
        edges(0, 2);
        `CHK("zero halts", 16'h0002, count_value)
        wr(OFS_PERIOD, 32'h5);
        `CHK("restart zero", 16'h0000, count_value)
        edges(0, 1);
        `CHK("restart up", 16'h0001, count_value)
    endtask : t_zero

    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence; a second reset lands while the count and flags are live
    initial begin
        presetn = 1'b0;
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = 8'h00;
        pwdata  = 32'h0;
        clks    = 3'b000;
        err_count = 0;
        n_checks  = 0;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_stop();
        t_cont();
        t_div();
        t_up();
        t_updn();
        t_zero();
        wr(OFS_COUNT, 32'h1234);
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        `CHK("rst count", 16'h0000, count_value)
        `CHK("rst roll", 1'b0, rollover_flag)
        rd_chk(OFS_CTRL, 32'h0, "rst ctrl");
        results();
    end
endmodule : tb_timer_counter_core
`default_nettype wire
